// file: design/msc_cfg.svh
// Constants of the measuring sequence control block: timing, register map, fields.
// Assumes a 25 MHz system clock and an APB master with 32-bit data.
`ifndef MSC_CFG_SVH
`define MSC_CFG_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define MSC_CLK_HZ 25000000
`define MSC_SEC_S 1
`define MSC_SEC_CYC (`MSC_CLK_HZ * `MSC_SEC_S)
`define MSC_ABORT_MS 500
`define MSC_ABORT_CYC ((`MSC_CLK_HZ / 1000) * `MSC_ABORT_MS)

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define MSC_OFS_CTRL 8'h00
`define MSC_OFS_EDIT 8'h04
`define MSC_OFS_STAT 8'h08
`define MSC_OFS_FEAT 8'h0C
`define MSC_OFS_SAVED 8'h10
`define MSC_OFS_TIMES 8'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MSC_CTRL_AUTO_BIT 0
`define MSC_CTRL_FUNC_LSB 4
`define MSC_EDIT_TGT_LSB 12
`define MSC_TIMES_PAUSE_LSB 10
`define MSC_TIMES_DELAY_LSB 20

// ----------------------------------------
// Function codes and edit targets
// ----------------------------------------
`define MSC_FN_PLAIN 3'h0
`define MSC_FN_MAX 3'h1
`define MSC_FN_MIN 3'h2
`define MSC_FN_SUM 3'h3
`define MSC_FN_DIFF 3'h4
`define MSC_FN_MEAN 3'h5
`define MSC_TGT_MODE 3'h0
`define MSC_TGT_FUNC 3'h1
`define MSC_TGT_TIMER 3'h2
`define MSC_TGT_PAUSE 3'h3
`define MSC_TGT_DELAY 3'h4

// ----------------------------------------
// Reset values and mean shift
// ----------------------------------------
`define MSC_RST_AUTO 1'h0
`define MSC_RST_FUNC 3'h0
`define MSC_RST_SECS 10'h000
`define MSC_MEAN_SHIFT 3

`endif

// file: design/msc_pkg.sv
// Types shared by the measuring sequence control block.
// Assumes the constants header is on the include path.
package msc_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } msc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } msc_apb_rsp_t;

  typedef struct packed {
    logic start;
    logic menu;
    logic data;
    logic ref_key;
  } msc_keys_t;

  typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_MEAS, ST_PAUSE, ST_ABORT, ST_MENU} msc_state_t;
  typedef enum logic [2:0] {DW_STD, DW_WAIT, DW_MEASURE, DW_PAUSE, DW_ABORT, DW_MENU} msc_disp_t;
  typedef enum logic [1:0] {ED_NONE, ED_EDITING, ED_FLASH} msc_edit_t;

endpackage

// file: design/msc_top.sv
// Measuring sequence control: manual and automatic runs, settings editor, APB registers.
// Assumes key pins are asynchronous, samples arrive on clk_sys with meas_valid.
//
// Behaviour
// - Manual: start begins measuring; later start clears max, min and mean.
// - Automatic: start begins measuring; second start ends it and shows result.
// - Automatic with nonzero period: measurement ends itself when period elapses.
// - With a pause configured, next measurement starts after the pause elapses.
// - Start during the measure and pause series terminates the whole series.
// - Mode marker shown while an automatic measurement runs.
// - Setting commits on second start while flashing; data or ref returns to editing.
// - Measurement period held in whole seconds, entered as decimal digits.
// - Pause period held as a seconds setting.
// - Automatic mode shows measure word while measuring, pause word while pausing.
// - Operator termination of a series by start briefly shows an abort word.
// - Feature computed from max, min, sum, difference, mean or plain; continuously in manual mode only.
// - Plain function in manual mode shows the current value while idle or measuring.
// - Manual maximum changes only on a larger value or a restart.
// - Manual minimum changes only on a smaller value or a restart.
// - Manual sum, difference, mean update continuously; start saves and restarts.
// - Automatic result computed at period end and held through the pause.
// - Automatic plain function shows the last measured value at period end.
// - Series continues until start or until the menu key opens the menu.
// - Start delay in seconds postpones measuring; wait word shown meanwhile.
// - Menu entry refused while a measurement runs; in automatic mode start ends it first.
`timescale 1ns/1ps
`include "msc_cfg.svh"

module msc_top #(
  parameter int SEC_CYC = `MSC_SEC_CYC,
  parameter int ABORT_CYC = `MSC_ABORT_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire msc_pkg::msc_apb_req_t apb_req,
  output msc_pkg::msc_apb_rsp_t apb_rsp,
  input wire msc_pkg::msc_keys_t keys_raw,
  input wire logic meas_valid,
  input wire logic signed [15:0] meas_value,
  output logic signed [17:0] feature_value,
  output logic signed [17:0] saved_value,
  output msc_pkg::msc_disp_t disp_word,
  output logic mode_marker,
  output logic accum_clear
);
  import msc_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    msc_keys_t keys_s1;
    msc_keys_t keys_s2;
    msc_keys_t keys_s3;
    msc_state_t st;
    msc_disp_t disp;
    logic auto_mode;
    logic [2:0] func;
    logic [9:0] timer_s;
    logic [9:0] pause_s;
    logic [9:0] delay_s;
    msc_edit_t edit;
    logic [2:0] edit_tgt;
    logic [11:0] edit_val;
    logic [24:0] tick_cnt;
    logic [9:0] sec_cnt;
    logic acc_any;
    logic signed [15:0] acc_max;
    logic signed [15:0] acc_min;
    logic signed [15:0] acc_mean;
    logic signed [15:0] last_val;
    logic signed [17:0] feature;
    logic signed [17:0] saved;
    logic marker;
    logic clr_pulse;
    msc_apb_rsp_t rsp;
  } msc_regs_t;

  msc_regs_t q, n;
  logic pr_start, pr_menu, pr_back;

  // Pressed edges look only at the second and third stages
  assign pr_start = q.keys_s2.start & ~q.keys_s3.start;
  assign pr_menu = q.keys_s2.menu & ~q.keys_s3.menu;
  assign pr_back = (q.keys_s2.data & ~q.keys_s3.data) | (q.keys_s2.ref_key & ~q.keys_s3.ref_key);

  function automatic logic [9:0] bcd_secs(input logic [11:0] v);
    logic [13:0] s;
    s = 14'(v[11:8]) * 14'h0064 + 14'(v[7:4]) * 14'h000A + 14'(v[3:0]);
    return s[9:0];
  endfunction

  function automatic logic signed [17:0] feat_of(input msc_regs_t r);
    logic signed [17:0] f;
    f = 18'(r.last_val);
    unique case (r.func)
      `MSC_FN_MAX: f = 18'(r.acc_max);
      `MSC_FN_MIN: f = 18'(r.acc_min);
      `MSC_FN_SUM: f = 18'(r.acc_max) + 18'(r.acc_min);
      `MSC_FN_DIFF: f = 18'(r.acc_max) - 18'(r.acc_min);
      `MSC_FN_MEAN: f = 18'(r.acc_mean);
      default: f = 18'(r.last_val);
    endcase
    return f;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic clr;
    logic enter;
    logic access;
    logic sec_tick;
    logic signed [16:0] dm;
    clr = 1'b0;
    enter = 1'b0;
    access = apb_req.psel & apb_req.penable;
    sec_tick = (q.tick_cnt == 25'(SEC_CYC - 1));
    dm = 17'sh00000;
    n = q;
    n.keys_s1 = keys_raw;
    n.keys_s2 = q.keys_s1;
    n.keys_s3 = q.keys_s2;
    n.clr_pulse = 1'b0;
    n.tick_cnt = sec_tick ? 25'h0000000 : q.tick_cnt + 25'h0000001;
    n.sec_cnt = sec_tick ? q.sec_cnt + 10'h001 : q.sec_cnt;

    unique case (q.st)
      ST_IDLE: begin
        if (pr_menu) begin
          n.st = ST_MENU;
          enter = 1'b1;
        end else if (pr_start) begin
          n.st = (q.delay_s != `MSC_RST_SECS) ? ST_WAIT : ST_MEAS;
          clr = 1'b1;
          enter = 1'b1;
        end
      end
      ST_WAIT: begin
        if (pr_start) begin
          n.st = ST_IDLE;
          enter = 1'b1;
        end else if (q.sec_cnt >= q.delay_s) begin
          n.st = ST_MEAS;
          clr = 1'b1;
          enter = 1'b1;
        end
      end
      ST_MEAS: begin
        if (pr_start && !q.auto_mode) begin
          n.saved = feat_of(q);
          clr = 1'b1;
          enter = 1'b1;
        end else if (pr_start) begin
          n.feature = feat_of(q);
          n.st = (q.pause_s != `MSC_RST_SECS) ? ST_ABORT : ST_IDLE;
          enter = 1'b1;
        end else if (q.auto_mode && q.timer_s != `MSC_RST_SECS && q.sec_cnt >= q.timer_s) begin
          n.feature = feat_of(q);
          n.st = (q.pause_s != `MSC_RST_SECS) ? ST_PAUSE : ST_IDLE;
          enter = 1'b1;
        end
      end
      ST_PAUSE: begin
        // start or menu end the series
        if (pr_start) begin
          n.st = ST_ABORT;
          enter = 1'b1;
        end else if (pr_menu) begin
          n.st = ST_MENU;
          enter = 1'b1;
        end else if (q.sec_cnt >= q.pause_s) begin
          n.st = ST_MEAS;
          clr = 1'b1;
          enter = 1'b1;
        end
      end
      ST_ABORT: begin
        n.tick_cnt = q.tick_cnt + 25'h0000001;
        if (q.tick_cnt >= 25'(ABORT_CYC - 1)) begin
          n.st = ST_IDLE;
          enter = 1'b1;
        end
      end
      ST_MENU: begin
        if (pr_start && q.edit == ED_EDITING) begin
          n.edit = ED_FLASH;
        end else if (pr_start && q.edit == ED_FLASH) begin
          n.edit = ED_NONE;
          unique case (q.edit_tgt)
            `MSC_TGT_MODE: n.auto_mode = q.edit_val[0];
            `MSC_TGT_FUNC: n.func = q.edit_val[2:0];
            `MSC_TGT_TIMER: n.timer_s = bcd_secs(q.edit_val);
            `MSC_TGT_PAUSE: n.pause_s = bcd_secs(q.edit_val);
            `MSC_TGT_DELAY: n.delay_s = bcd_secs(q.edit_val);
            default: n.edit = ED_NONE;
          endcase
        end else if (pr_back && q.edit == ED_FLASH) begin
          n.edit = ED_EDITING;
        end else if (pr_start) begin
          n.st = ST_IDLE;
          enter = 1'b1;
        end
      end
      default: begin
        n.st = ST_IDLE;
        enter = 1'b1;
      end
    endcase

    if (enter) begin
      n.tick_cnt = 25'h0000000;
      n.sec_cnt = 10'h000;
    end

    // Samples only accumulate while measuring; a clear drops the sample of that cycle
    if (meas_valid) begin
      n.last_val = meas_value;
    end
    if (clr) begin
      n.acc_any = 1'b0;
      n.clr_pulse = 1'b1;
    end else if (meas_valid && q.st == ST_MEAS) begin
      n.acc_any = 1'b1;
      if (!q.acc_any) begin
        n.acc_max = meas_value;
        n.acc_min = meas_value;
        n.acc_mean = meas_value;
      end else begin
        if (meas_value > q.acc_max) begin
          n.acc_max = meas_value;
        end
        if (meas_value < q.acc_min) begin
          n.acc_min = meas_value;
        end
        // Running mean by shift; avoids a divider at the cost of exactness
        dm = 17'(meas_value) - 17'(q.acc_mean);
        n.acc_mean = q.acc_mean + 16'(dm >>> `MSC_MEAN_SHIFT);
      end
    end

    if (!q.auto_mode && (q.st == ST_MEAS || q.st == ST_IDLE)) begin
      n.feature = (q.func == `MSC_FN_PLAIN || !q.acc_any) ? 18'(q.last_val) : feat_of(q);
    end

    unique case (n.st)
      ST_WAIT: n.disp = DW_WAIT;
      ST_MEAS: n.disp = n.auto_mode ? DW_MEASURE : DW_STD;
      ST_PAUSE: n.disp = DW_PAUSE;
      ST_ABORT: n.disp = DW_ABORT;
      ST_MENU: n.disp = DW_MENU;
      default: n.disp = DW_STD;
    endcase
    n.marker = n.auto_mode && n.st == ST_MEAS;

    // ----------------------------------------
    // APB slave, one wait state
    // ----------------------------------------
    n.rsp.pready = access & ~q.rsp.pready;
    if (access && !q.rsp.pready) begin
      n.rsp.pslverr = 1'b0;
      n.rsp.prdata = 32'h00000000;
      unique case (apb_req.paddr)
        `MSC_OFS_CTRL: begin
          n.rsp.prdata[`MSC_CTRL_AUTO_BIT] = q.auto_mode;
          n.rsp.prdata[`MSC_CTRL_FUNC_LSB +: 3] = q.func;
        end
        `MSC_OFS_EDIT: n.rsp.prdata = {15'h0000, q.edit, q.edit_tgt, q.edit_val};
        `MSC_OFS_STAT: n.rsp.prdata = {22'h000000, q.marker, q.acc_any, q.disp, 2'h0, q.st};
        `MSC_OFS_FEAT: n.rsp.prdata = 32'(q.feature);
        `MSC_OFS_SAVED: n.rsp.prdata = 32'(q.saved);
        `MSC_OFS_TIMES: n.rsp.prdata = {2'h0, q.delay_s, q.pause_s, q.timer_s};
        default: n.rsp.pslverr = 1'b1;
      endcase
    end else if (!access) begin
      n.rsp.pslverr = 1'b0;
    end
    if (access && q.rsp.pready && apb_req.pwrite && apb_req.paddr == `MSC_OFS_EDIT) begin
      n.edit = ED_EDITING;
      n.edit_tgt = apb_req.pwdata[`MSC_EDIT_TGT_LSB +: 3];
      n.edit_val = apb_req.pwdata[11:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.disp <= DW_STD;
      q.edit <= ED_NONE;
      q.auto_mode <= `MSC_RST_AUTO;
      q.func <= `MSC_RST_FUNC;
    end else begin
      q <= n;
    end
  end

  assign apb_rsp = q.rsp;
  assign feature_value = q.feature;
  assign saved_value = q.saved;
  assign disp_word = q.disp;
  assign mode_marker = q.marker;
  assign accum_clear = q.clr_pulse;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_manual_restart;
    (q.st == ST_MEAS && !q.auto_mode && pr_start) |=> (q.st == ST_MEAS && !q.acc_any && accum_clear);
  endproperty
  a_manual_restart: assert property (p_manual_restart) else $error("manual restart missed");

  property p_auto_end;
    (q.st == ST_MEAS && q.auto_mode && pr_start && q.pause_s == 10'h000) |=> q.st == ST_IDLE;
  endproperty
  a_auto_end: assert property (p_auto_end) else $error("auto stop missed");

  property p_timer_end;
    (q.st == ST_MEAS && q.auto_mode && q.timer_s != 10'h000 && q.sec_cnt >= q.timer_s)
      |=> (q.st == ST_PAUSE || q.st == ST_IDLE || q.st == ST_ABORT);
  endproperty
  a_timer_end: assert property (p_timer_end) else $error("period did not end");

  property p_pause_resume;
    (q.st == ST_PAUSE && q.sec_cnt >= q.pause_s && !pr_start && !pr_menu)
      |=> (q.st == ST_MEAS && !q.acc_any && disp_word == DW_MEASURE);
  endproperty
  a_pause_resume: assert property (p_pause_resume) else $error("pause did not resume");

  property p_series_abort;
    (q.st == ST_PAUSE && pr_start) |=> disp_word == DW_ABORT;
  endproperty
  a_series_abort: assert property (p_series_abort) else $error("series not aborted");

  property p_marker;
    (q.st == ST_MEAS && q.auto_mode) |-> mode_marker;
  endproperty
  a_marker: assert property (p_marker) else $error("marker missing");

  property p_back_edit;
    (q.st == ST_MENU && q.edit == ED_FLASH && pr_back && !pr_start && !apb_req.psel)
      |=> q.edit == ED_EDITING;
  endproperty
  a_back_edit: assert property (p_back_edit) else $error("flash did not return");

  property p_hold_pause;
    (q.st == ST_PAUSE && $past(q.st) == ST_PAUSE) |-> $stable(feature_value);
  endproperty
  a_hold_pause: assert property (p_hold_pause) else $error("result moved in pause");

  property p_wait_word;
    q.st == ST_WAIT |-> disp_word == DW_WAIT;
  endproperty
  a_wait_word: assert property (p_wait_word) else $error("wait word missing");

  property p_menu_refused;
    (q.st == ST_MEAS && pr_menu) |=> q.st != ST_MENU;
  endproperty
  a_menu_refused: assert property (p_menu_refused) else $error("menu opened mid run");

  c_manual_restart: cover property (q.st == ST_MEAS && !q.auto_mode && pr_start);
  c_pause_to_meas: cover property (q.st == ST_PAUSE ##1 q.st == ST_MEAS);
  c_abort: cover property (q.st == ST_ABORT ##1 q.st == ST_IDLE);
  c_commit: cover property (q.edit == ED_FLASH && pr_start && q.st == ST_MENU);

endmodule // msc_top

// file: bench/msc_keypad.sv
// Operator keypad and fixture start contact, seen from the sequence control block.
// Assumes presses are requested by the bench; key lines rest low between presses.
`timescale 1ns/1ps

module msc_keypad (
  input wire logic clk_sys,
  output msc_pkg::msc_keys_t keys
);
  import msc_pkg::*;

  // ----------------------------------------
  // Key presses
  // ----------------------------------------
  initial keys = '0;

  // press of the keys in mask
  // Low gap first, so back-to-back presses still give a clean rising level
  task automatic press(input logic [3:0] mask);
    repeat (3) @(posedge clk_sys);
    keys <= msc_keys_t'(mask);
    repeat (4) @(posedge clk_sys);
    keys <= '0;
  endtask
endmodule // msc_keypad

// file: bench/tb_measuring_sequence_control.sv
// Self-checking bench for the measuring sequence control block.
// Assumes shortened timing: one second is 20 cycles, the abort word lasts 8 cycles.
`timescale 1ns/1ps
`include "msc_cfg.svh"

module tb_measuring_sequence_control;
  import msc_pkg::*;

  localparam logic [3:0] K_START = 4'h8;
  localparam logic [3:0] K_MENU = 4'h4;
  localparam logic [3:0] K_DATA = 4'h2;

  logic clk_sys;
  logic rst;
  msc_apb_req_t apb_req;
  msc_apb_rsp_t apb_rsp;
  msc_keys_t keys_raw;
  logic meas_valid;
  logic signed [15:0] meas_value;
  logic signed [17:0] feature_value;
  logic signed [17:0] saved_value;
  msc_disp_t disp_word;
  logic mode_marker;
  logic accum_clear;
  int n_errors = 0;
  int num_checks = 0;
  int n_clr = 0;
  int cyc = 0;
  int n0;
  logic [31:0] rd;
  logic er;
  // Results of samples 3, 7, 4, then of one sample 2 after a restart
  int exp1 [6] = '{4, 7, 3, 10, 4, 3};
  int exp2 [6] = '{2, 2, 2, 4, 0, 2};

  msc_top #(.SEC_CYC(20), .ABORT_CYC(8)) uut (
    .clk_sys(clk_sys),
    .rst(rst),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .keys_raw(keys_raw),
    .meas_valid(meas_valid),
    .meas_value(meas_value),
    .feature_value(feature_value),
    .saved_value(saved_value),
    .disp_word(disp_word),
    .mode_marker(mode_marker),
    .accum_clear(accum_clear)
  );

  msc_keypad kp (.clk_sys(clk_sys), .keys(keys_raw));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // Clear pulse count and run limit
  // ----------------------------------------
  always @(posedge clk_sys) begin
    cyc++;
    if (accum_clear === 1'b1) n_clr++;
    if (cyc == 20000) begin
      n_errors++;
      $display("[FAIL] run_length expected below %0d seen %0d", 20000, cyc);
      finish_test();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
    num_checks++;
    if (got !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, e, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    int i;
    @(posedge clk_sys);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (apb_rsp.pready !== 1'b1);
    // One wait state: ready is seen on the second access-phase edge
    chk("pready_wait", 32'h2, 32'(i));
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_req <= '0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] addr, input logic [31:0] m,
                        input logic [31:0] e);
    apb(1'b0, addr, 32'h0);
    chk(what, e, rd & m);
  endtask

  task automatic sample(input logic signed [15:0] v);
    @(posedge clk_sys);
    meas_valid <= 1'b1;
    meas_value <= v;
    @(posedge clk_sys);
    meas_valid <= 1'b0;
  endtask

  task automatic wait_disp(input msc_disp_t w, input int lim);
    int i;
    for (i = 0; i < lim && disp_word !== w; i++) @(posedge clk_sys);
    chk("disp_word", 32'(w), 32'(disp_word));
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
  endtask

  // Opens the menu from idle, commits one setting, leaves the menu
  task automatic set_setting(input logic [2:0] tgt, input logic [11:0] val, input logic bounce);
    kp.press(K_MENU);
    wait_disp(DW_MENU, 8);
    apb(1'b1, `MSC_OFS_EDIT, (32'(tgt) << `MSC_EDIT_TGT_LSB) | 32'(val));
    kp.press(K_START);
    rd_chk("edit_stage", `MSC_OFS_EDIT, 32'h0001_8000, 32'h0001_0000); // value flashes
    if (bounce) begin
      kp.press(K_DATA);
      rd_chk("edit_stage", `MSC_OFS_EDIT, 32'h0001_8000, 32'h0000_8000); // back to edit
      kp.press(K_START);
    end
    kp.press(K_START);
    rd_chk("edit_stage", `MSC_OFS_EDIT, 32'h0001_8000, 32'h0000_0000); // committed
    kp.press(K_START);
    wait_disp(DW_STD, 8);
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    apb_req = '0;
    meas_valid = 1'b0;
    meas_value = '0;
    do_reset();
    rd_chk("ctrl", `MSC_OFS_CTRL, 32'hFFFF_FFFF, 32'h0); // plain manual default
    rd_chk("times", `MSC_OFS_TIMES, 32'hFFFF_FFFF, 32'h0); // zero periods
    apb(1'b1, `MSC_OFS_CTRL, 32'h0000_0051);
    rd_chk("ctrl", `MSC_OFS_CTRL, 32'hFFFF_FFFF, 32'h0); // read-only control
    apb(1'b0, 8'h18, 32'h0);
    chk("pslverr", 32'h1, 32'(er));
    chk("prdata", 32'h0, rd);
    chk("disp_word", 32'(DW_STD), 32'(disp_word));
    $display("test reset_values done");

    for (int fn = 0; fn < 6; fn++) begin
      do_reset();
      if (fn != 0) set_setting(`MSC_TGT_FUNC, 12'(fn), 1'b0);
      rd_chk("ctrl_func", `MSC_OFS_CTRL, 32'h70, 32'(fn) << `MSC_CTRL_FUNC_LSB); // function
      kp.press(K_START);
      sample(3);
      sample(7);
      sample(4);
      repeat (3) @(posedge clk_sys);
      chk("feature", 32'(exp1[fn]), 32'(feature_value)); // running result
      kp.press(K_MENU);
      rd_chk("state", `MSC_OFS_STAT, 32'h7, 32'h2); // menu refused
      n0 = n_clr;
      kp.press(K_START);
      repeat (3) @(posedge clk_sys);
      chk("saved", 32'(exp1[fn]), 32'(saved_value)); // result saved
      chk("clears", 32'h1, 32'(n_clr - n0)); // accumulators cleared
      sample(2);
      repeat (3) @(posedge clk_sys);
      chk("feature", 32'(exp2[fn]), 32'(feature_value)); // fresh run
      $display("test manual function %0d done", fn);
    end

    do_reset();
    set_setting(`MSC_TGT_MODE, 12'h001, 1'b0);
    set_setting(`MSC_TGT_TIMER, 12'h002, 1'b0);
    set_setting(`MSC_TGT_PAUSE, 12'h001, 1'b0);
    set_setting(`MSC_TGT_FUNC, 12'(`MSC_FN_MAX), 1'b0);
    rd_chk("ctrl_auto", `MSC_OFS_CTRL, 32'h1, 32'h1); // automatic mode set
    rd_chk("times", `MSC_OFS_TIMES, 32'h000F_FFFF, 32'h0000_0402); // seconds held
    n0 = n_clr;
    kp.press(K_START);
    wait_disp(DW_MEASURE, 8); // measure word
    chk("marker", 32'h1, 32'(mode_marker)); // marker shown
    sample(5);
    sample(9);
    kp.press(K_MENU);
    chk("disp_word", 32'(DW_MEASURE), 32'(disp_word)); // menu refused
    chk("feature", 32'h0, 32'(feature_value)); // held until period end
    wait_disp(DW_PAUSE, 40); // period ends alone
    chk("feature", 32'h9, 32'(feature_value)); // maximum latched
    chk("marker", 32'h0, 32'(mode_marker)); // marker off in pause
    wait_disp(DW_MEASURE, 30); // next measurement
    // Let the clear counter take the pulse of this edge first
    @(posedge clk_sys);
    chk("clears", 32'h2, 32'(n_clr - n0)); // cleared per period
    kp.press(K_START);
    wait_disp(DW_ABORT, 6); // abort word
    wait_disp(DW_STD, 16); // series over
    kp.press(K_START);
    wait_disp(DW_PAUSE, 50); // period ends alone
    kp.press(K_MENU);
    wait_disp(DW_MENU, 8); // menu ends series
    $display("test automatic series done");

    do_reset();
    set_setting(`MSC_TGT_MODE, 12'h001, 1'b0);
    set_setting(`MSC_TGT_DELAY, 12'h001, 1'b1); // data key reopens edit
    rd_chk("times", `MSC_OFS_TIMES, 32'hFFFF_FFFF, 32'h0010_0000); // delay held
    kp.press(K_START); // contact start
    wait_disp(DW_WAIT, 6); // wait word
    wait_disp(DW_MEASURE, 30); // delayed start
    sample(6);
    sample(8);
    kp.press(K_START);
    wait_disp(DW_STD, 8); // operator end
    chk("feature", 32'h8, 32'(feature_value)); // last value shown
    $display("test automatic delay done");
    finish_test();
  end
endmodule // tb_measuring_sequence_control
